// >>> rtl/ecfc_tdm_port.sv
// Timeslot decoder of one framed PCM port
`timescale 1ns/1ps
`default_nettype none
`include "ecfc_defines.svh"

module ecfc_tdm_port
  import ecfc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] slot,
  input wire ecfc_bus_mode_t mode,
  output logic ch_a_slot,
  output logic ch_b_slot
);

  ecfc_port_state_t q; // Registered state
  ecfc_port_state_t next_q; // Next state
  logic [4:0] base; // First slot of this port's pair

  // Slot pair follows the port's own bus mode
  always_comb begin
    base = (mode == ECFC_BUS_MODE2) ? `ECFC_MODE2_BASE : `ECFC_MODE1_BASE;
    next_q.ch_a = (slot == base); // see R18 see R20
    next_q.ch_b = (slot == (base + 5'h01)); // see R18 see R20
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign ch_a_slot = q.ch_a;
  assign ch_b_slot = q.ch_b;

  property p_slot_pair;
    @(posedge clk) disable iff (rst)
      !$past(rst) |-> ch_a_slot == ($past(slot) ==
        (($past(mode) == ECFC_BUS_MODE2) ? 5'h02 : 5'h00));
  endproperty
  a_slot_pair: // see R18 see R20
    assert property (p_slot_pair) else $error("channel A slot wrong");

endmodule
`default_nettype wire

// >>> rtl/ecfc_top.sv
// Function control, strap decode and frame timing of the echo canceller
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "ecfc_defines.svh"

// Function
// R01 - Both config pins low selects controller mode
// R02 - Attenuator off standalone, else control bit
// R03 - Double-talk always detected, freezes adaptation
// R04 - Controller mode threshold from two registers
// R05 - Standalone tone detect drives outputs low
// R06 - Outside logic bypasses canceller on tone
// R07 - Controller tone-disable bit stops tone detectors
// R08 - Standalone reversal pin requires phase reversals
// R09 - Controller bit drops phase reversal need
// R10 - Standalone NONLINEAR_PROC_PIN pin enables processor
// R11 - Controller NONLINEAR_PROC_PIN-disable bit turns processor off
// R12 - Law pin selects A-law or mu-law
// R13 - Format pin selects sign-magnitude or standard
// R14 - Standalone narrow-band detect freezes adaptation
// R15 - Controller bit disables narrow-band detection
// R16 - Standalone offset-null filter always runs
// R17 - Controller bit bypasses offset-null filter
// R18 - Mode 1 channels in slots 0, 1
// R19 - Delayed frame pulse four slots late
// R20 - Mode 2 slots 2, 3; ports independent
// R21 - Standalone ignores register function bits
module ecfc_top
  import ecfc_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic RST,
  input wire logic [2:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic CONFIG_SELECT_A,
  input wire logic CONFIG_SELECT_B,
  input wire logic PHASE_REVERSAL_SELECT,
  input wire logic NONLINEAR_PROC_PIN,
  input wire logic LAW_SELECT,
  input wire logic FORMAT_SELECT,
  input wire logic BIT_CLOCK_IN,
  input wire logic FRAME_PULSE_IN_N,
  input wire logic TONE_HIT_A,
  input wire logic TONE_HIT_B,
  input wire logic DOUBLE_TALK,
  input wire logic NARROWBAND_HIT,
  output ecfc_func_t FUNC,
  output logic [15:0] DT_THRESHOLD,
  output logic ADAPT_FREEZE,
  output logic TONE_DETECT_OUT_A_N,
  output logic TONE_DETECT_OUT_B_N,
  output logic DELAYED_FRAME_PULSE_OUT_N,
  output logic [1:0] CANCELLER_A_SLOT,
  output logic [1:0] CANCELLER_B_SLOT
);

  ecfc_state_t q; // Registered state
  ecfc_state_t next_q; // Next state
  logic [7:0] pins; // Raw asynchronous pins
  logic ctl; // Controller mode from synced straps
  logic fp; // Synced frame pulse, active low
  logic bclk_fall; // Falling edge of the bit clock

  assign pins = {FRAME_PULSE_IN_N, BIT_CLOCK_IN, FORMAT_SELECT, LAW_SELECT,
                 NONLINEAR_PROC_PIN, PHASE_REVERSAL_SELECT,
                 CONFIG_SELECT_B, CONFIG_SELECT_A};

  // Mode and bit-clock edge come only from the second sync stage
  assign ctl = !q.sync2[`ECFC_PIN_CFG_A] && !q.sync2[`ECFC_PIN_CFG_B];
  assign fp = q.sync2[`ECFC_PIN_FP_N];
  assign bclk_fall = q.bclk_d && !q.sync2[`ECFC_PIN_BCLK];

  // Next-state logic
  always_comb begin
    next_q = q;
    // Two-stage synchroniser for every pin
    next_q.sync1 = pins;
    next_q.sync2 = q.sync1;
    next_q.bclk_d = q.sync2[`ECFC_PIN_BCLK];
    next_q.tick = bclk_fall;

    // Register writes; stored even in standalone mode
    if (REG_WR) begin
      unique case (REG_ADDR)
        `ECFC_ADDR_CTRL1: next_q.atten_en = REG_WDATA[`ECFC_C1_ATTEN];
        `ECFC_ADDR_CTRL2: next_q.ctrl2 = REG_WDATA[4:0];
        `ECFC_ADDR_DT_THR1: next_q.thr1 = REG_WDATA;
        `ECFC_ADDR_DT_THR2: next_q.thr2 = REG_WDATA;
        `ECFC_ADDR_PORT_MODE: next_q.port_mode = REG_WDATA[1:0];
        default: begin
          // Status and unmapped writes are dropped
        end
      endcase
    end

    // Read data stands for exactly one cycle
    next_q.rdata = 8'h00;
    if (REG_RD) begin
      unique case (REG_ADDR)
        `ECFC_ADDR_CTRL1: next_q.rdata = {7'h00, q.atten_en};
        `ECFC_ADDR_CTRL2: next_q.rdata = {3'h0, q.ctrl2};
        `ECFC_ADDR_DT_THR1: next_q.rdata = q.thr1;
        `ECFC_ADDR_DT_THR2: next_q.rdata = q.thr2;
        `ECFC_ADDR_PORT_MODE: next_q.rdata = {6'h00, q.port_mode};
        `ECFC_ADDR_STATUS: next_q.rdata = {q.freeze, q.func.hpf_on,
          q.func.nb_det_on, q.func.nlp_on, q.func.need_phase_rev,
          q.func.tone_det_on, q.func.atten_on, q.func.controller_mode};
        default: next_q.rdata = 8'h00; // Unmapped reads zero
      endcase
    end

    // Function selection; standalone uses straps or fixed values
    next_q.func.controller_mode = ctl; // see R01
    next_q.func.law_alaw = q.sync2[`ECFC_PIN_LAW]; // see R12
    next_q.func.format_itu = q.sync2[`ECFC_PIN_FMT]; // see R13
    if (ctl) begin
      next_q.func.atten_on = q.atten_en; // see R02
      next_q.func.tone_det_on = !q.ctrl2[`ECFC_C2_TONE_DIS]; // see R07
      next_q.func.need_phase_rev = !q.ctrl2[`ECFC_C2_PHREV_DIS]; // see R09
      next_q.func.nlp_on = !q.ctrl2[`ECFC_C2_NLP_DIS]; // see R11
      next_q.func.nb_det_on = !q.ctrl2[`ECFC_C2_NB_DIS]; // see R15
      next_q.func.hpf_on = !q.ctrl2[`ECFC_C2_HPF_DIS]; // see R17
      next_q.thr_out = {q.thr2, q.thr1}; // see R04
    end else begin
      // Register bits are not consulted here
      next_q.func.atten_on = 1'b0; // see R02 see R21
      next_q.func.tone_det_on = 1'b1; // see R05 see R21
      next_q.func.need_phase_rev = q.sync2[`ECFC_PIN_REV]; // see R08
      next_q.func.nlp_on = q.sync2[`ECFC_PIN_NLP]; // see R10
      next_q.func.nb_det_on = 1'b1; // see R14 see R21
      next_q.func.hpf_on = 1'b1; // see R16 see R21
      next_q.thr_out = {`ECFC_RST_DT_THR2, `ECFC_RST_DT_THR1};
    end

    // Adaptation freeze: double-talk always, narrow-band when enabled
    next_q.freeze = DOUBLE_TALK || // see R03
      (NARROWBAND_HIT && next_q.func.nb_det_on); // see R14 see R15

    // Tone outputs low on detection; bypassing is left to the user
    next_q.td_a_n = !(TONE_HIT_A && next_q.func.tone_det_on); // see R05
    next_q.td_b_n = !(TONE_HIT_B && next_q.func.tone_det_on); // see R07

    // Frame timing on each bit-clock falling edge
    if (bclk_fall) begin
      next_q.fp_d = fp;
      if (!fp && q.fp_d) begin
        next_q.cnt = 9'h000;
      end else begin
        next_q.cnt = q.cnt + 9'h001;
      end
      // One bit clock low, fixed slot offset in every bus mode
      next_q.fp_out_n = (next_q.cnt != `ECFC_FP_DELAY_BCLK); // see R19
    end
  end

  // State register with defined reset values
  always_ff @(posedge SYS_CLK) begin
    if (RST) begin
      q <= '0;
      q.sync1 <= 8'hff;
      q.sync2 <= 8'hff;
      q.bclk_d <= 1'b1;
      q.fp_d <= 1'b1;
      q.atten_en <= `ECFC_RST_CTRL1;
      q.ctrl2 <= `ECFC_RST_CTRL2;
      q.thr1 <= `ECFC_RST_DT_THR1;
      q.thr2 <= `ECFC_RST_DT_THR2;
      q.port_mode <= `ECFC_RST_PORT_MODE;
      q.td_a_n <= 1'b1;
      q.td_b_n <= 1'b1;
      q.fp_out_n <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  // One slot decoder per port, each with its own mode
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_port
      ecfc_tdm_port u_port (
        .clk(SYS_CLK),
        .rst(RST),
        .slot(q.cnt[8:4]),
        .mode(ecfc_bus_mode_t'(q.port_mode[gi])),
        .ch_a_slot(CANCELLER_A_SLOT[gi]),
        .ch_b_slot(CANCELLER_B_SLOT[gi])
      );
    end
  endgenerate

  assign REG_RDATA = q.rdata;
  assign FUNC = q.func;
  assign DT_THRESHOLD = q.thr_out;
  assign ADAPT_FREEZE = q.freeze;
  assign TONE_DETECT_OUT_A_N = q.td_a_n;
  assign TONE_DETECT_OUT_B_N = q.td_b_n;
  assign DELAYED_FRAME_PULSE_OUT_N = q.fp_out_n;

  // Checks next to the logic above
  property p_mode;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.controller_mode == $past(ctl);
  endproperty
  a_mode: // see R01
    assert property (p_mode) else $error("mode decode wrong");

  property p_atten;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.atten_on == ($past(ctl) && $past(q.atten_en));
  endproperty
  a_atten: // see R02
    assert property (p_atten) else $error("attenuator wrong");

  property p_dt_freeze;
    @(posedge SYS_CLK) disable iff (RST)
      DOUBLE_TALK |=> ADAPT_FREEZE;
  endproperty
  a_dt_freeze: // see R03
    assert property (p_dt_freeze) else $error("no freeze on double-talk");

  property p_thr;
    @(posedge SYS_CLK) disable iff (RST)
      ctl |=> DT_THRESHOLD == {$past(q.thr2), $past(q.thr1)};
  endproperty
  a_thr: // see R04
    assert property (p_thr) else $error("threshold not from registers");

  property p_tone_out;
    @(posedge SYS_CLK) disable iff (RST)
      (!ctl && TONE_HIT_A) |=> !TONE_DETECT_OUT_A_N;
  endproperty
  a_tone_out: // see R05
    assert property (p_tone_out) else $error("tone output not low");

  property p_tone_dis;
    @(posedge SYS_CLK) disable iff (RST)
      (ctl && q.ctrl2[`ECFC_C2_TONE_DIS]) |=>
        TONE_DETECT_OUT_A_N && TONE_DETECT_OUT_B_N && !FUNC.tone_det_on;
  endproperty
  a_tone_dis: // see R07
    assert property (p_tone_dis) else $error("tone detector not off");

  property p_phrev;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.need_phase_rev == ($past(ctl) ?
        !$past(q.ctrl2[`ECFC_C2_PHREV_DIS]) :
        $past(q.sync2[`ECFC_PIN_REV]));
  endproperty
  a_phrev: // see R08 see R09
    assert property (p_phrev) else $error("phase reversal select wrong");

  property p_nlp;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.nlp_on == ($past(ctl) ?
        !$past(q.ctrl2[`ECFC_C2_NLP_DIS]) :
        $past(q.sync2[`ECFC_PIN_NLP]));
  endproperty
  a_nlp: // see R10 see R11
    assert property (p_nlp) else $error("nonlinear processor wrong");

  property p_law_fmt;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.law_alaw == $past(q.sync2[`ECFC_PIN_LAW]) &&
        FUNC.format_itu == $past(q.sync2[`ECFC_PIN_FMT]);
  endproperty
  a_law_fmt: // see R12 see R13
    assert property (p_law_fmt) else $error("law or format wrong");

  property p_nb;
    @(posedge SYS_CLK) disable iff (RST)
      (NARROWBAND_HIT && (!ctl || !q.ctrl2[`ECFC_C2_NB_DIS])) |=>
        ADAPT_FREEZE;
  endproperty
  a_nb: // see R14 see R15
    assert property (p_nb) else $error("no freeze on narrow-band");

  property p_hpf;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) |-> FUNC.hpf_on ==
        !($past(ctl) && $past(q.ctrl2[`ECFC_C2_HPF_DIS]));
  endproperty
  a_hpf: // see R16 see R17
    assert property (p_hpf) else $error("offset-null filter wrong");

  property p_fp_delay;
    @(posedge SYS_CLK) disable iff (RST)
      $fell(DELAYED_FRAME_PULSE_OUT_N) |->
        q.cnt == 9'h040 && $past(q.cnt) == 9'h03f;
  endproperty
  a_fp_delay: // see R19
    assert property (p_fp_delay) else $error("delayed frame pulse late");

  // The output pulse may only move on a bit-clock tick; a change between
  // ticks would mean the frame logic is running on the system clock
  property p_fp_tick;
    @(posedge SYS_CLK) disable iff (RST)
      !$past(RST) && $changed(DELAYED_FRAME_PULSE_OUT_N) |-> q.tick;
  endproperty
  a_fp_tick: // see R19
    assert property (p_fp_tick) else $error("frame pulse moved off a tick");

  // Frame start resets the bit counter on the same tick
  property p_frame_zero;
    @(posedge SYS_CLK) disable iff (RST)
      (bclk_fall && !fp && q.fp_d) |=> q.cnt == 9'h000;
  endproperty
  a_frame_zero: // see R19
    assert property (p_frame_zero) else $error("frame start missed");

  // Second tone output behaves like the first
  property p_tone_out_b;
    @(posedge SYS_CLK) disable iff (RST)
      (!ctl && TONE_HIT_B) |=> !TONE_DETECT_OUT_B_N;
  endproperty
  a_tone_out_b: // see R05
    assert property (p_tone_out_b) else $error("tone output B not low");

  // Narrow-band hits are masked once software turns detection off
  property p_nb_off;
    @(posedge SYS_CLK) disable iff (RST)
      (ctl && q.ctrl2[`ECFC_C2_NB_DIS] && !DOUBLE_TALK) |=> !ADAPT_FREEZE;
  endproperty
  a_nb_off: // see R15
    assert property (p_nb_off) else $error("narrow-band not masked");

  // Standalone settings never depend on what software wrote
  property p_fixed;
    @(posedge SYS_CLK) disable iff (RST)
      !ctl |=> !FUNC.atten_on && FUNC.tone_det_on && FUNC.nb_det_on &&
        FUNC.hpf_on;
  endproperty
  a_fixed: // see R02 see R14 see R16 see R21
    assert property (p_fixed) else $error("standalone setting not fixed");

  // Standalone threshold is the fixed default, not the registers
  property p_thr_fixed;
    @(posedge SYS_CLK) disable iff (RST)
      !ctl |=> DT_THRESHOLD == {`ECFC_RST_DT_THR2, `ECFC_RST_DT_THR1};
  endproperty
  a_thr_fixed: // see R21
    assert property (p_thr_fixed) else $error("standalone threshold wrong");

endmodule
`default_nettype wire

// >>> shared/ecfc_defines.svh
// Offsets, field positions, reset values and timing counts for ecfc
`ifndef ECFC_DEFINES_SVH
`define ECFC_DEFINES_SVH

`define ECFC_ADDR_CTRL1 3'h0
`define ECFC_ADDR_CTRL2 3'h1
`define ECFC_ADDR_DT_THR1 3'h2
`define ECFC_ADDR_DT_THR2 3'h3
`define ECFC_ADDR_PORT_MODE 3'h4
`define ECFC_ADDR_STATUS 3'h5

`define ECFC_C1_ATTEN 0
`define ECFC_C2_TONE_DIS 0
`define ECFC_C2_PHREV_DIS 1
`define ECFC_C2_NB_DIS 2
`define ECFC_C2_HPF_DIS 3
`define ECFC_C2_NLP_DIS 4

`define ECFC_RST_CTRL1 1'h0
`define ECFC_RST_CTRL2 5'h00
`define ECFC_RST_DT_THR1 8'h00
`define ECFC_RST_DT_THR2 8'h00
`define ECFC_RST_PORT_MODE 2'h0

`define ECFC_PIN_CFG_A 0
`define ECFC_PIN_CFG_B 1
`define ECFC_PIN_REV 2
`define ECFC_PIN_NLP 3
`define ECFC_PIN_LAW 4
`define ECFC_PIN_FMT 5
`define ECFC_PIN_BCLK 6
`define ECFC_PIN_FP_N 7

`define ECFC_BCLK_PER_SLOT 16
`define ECFC_FP_DELAY_SLOTS 4
`define ECFC_FP_DELAY_BCLK 9'h040
`define ECFC_MODE1_BASE 5'h00
`define ECFC_MODE2_BASE 5'h02

`endif

// >>> shared/ecfc_pkg.sv
// Types shared by the echo canceller function-control logic
`default_nettype none
package ecfc_pkg;

  // Framed bus mode of one port
  typedef enum logic [0:0] {
    ECFC_BUS_MODE1 = 1'b0,
    ECFC_BUS_MODE2 = 1'b1
  } ecfc_bus_mode_t;

  // Effective function settings, as seen by the canceller core
  typedef struct packed {
    logic controller_mode;
    logic atten_on;
    logic tone_det_on;
    logic need_phase_rev;
    logic nlp_on;
    logic nb_det_on;
    logic hpf_on;
    logic law_alaw;
    logic format_itu;
  } ecfc_func_t;

  // Whole state of the top module
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic bclk_d;
    logic fp_d;
    logic [8:0] cnt;
    logic atten_en;
    logic [4:0] ctrl2;
    logic [7:0] thr1;
    logic [7:0] thr2;
    logic [1:0] port_mode;
    logic [7:0] rdata;
    ecfc_func_t func;
    logic [15:0] thr_out;
    logic freeze;
    logic td_a_n;
    logic td_b_n;
    logic fp_out_n;
    logic tick;
  } ecfc_state_t;

  // State of one port's slot decoder
  typedef struct packed {
    logic ch_a;
    logic ch_b;
  } ecfc_port_state_t;

endpackage
`default_nettype wire

// >>> sim/ecfc_tdm_master.sv
// Far-side model: framed PCM bus master and external bypass logic
`timescale 1ns/1ps
`default_nettype none
module ecfc_tdm_master #(
  parameter int FRAME = 256
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic td_a_n,
  input wire logic td_b_n,
  output logic bclk,
  output logic fp_n,
  output logic probe,
  output logic [8:0] idx,
  output logic bypass_a,
  output logic bypass_b
);
  logic [2:0] ph; // Phase within one bit clock, eight system clocks

  // Bit index advances on each bit-clock fall, wraps at frame end
  always_ff @(posedge clk) begin
    if (rst) begin
      ph <= 3'h0;
      idx <= 9'h000;
    end else begin
      ph <= ph + 3'h1;
      if (ph == 3'h3) begin
        idx <= (idx == 9'(FRAME - 1)) ? 9'h000 : idx + 9'h001;
      end
    end
  end

  // Bit clock high in phases 0..3, so it falls entering phase 4
  assign bclk = ~ph[2];
  // Frame pulse spans the whole bit period around the frame's first fall
  assign fp_n = ~((idx == 9'(FRAME - 1) && !ph[2]) ||
                  (idx == 9'h000 && ph[2]));
  // Last cycle before the next fall: design outputs have settled by now
  assign probe = (ph == 3'h3);
  // Outside logic bypasses a canceller while its tone output is low
  assign bypass_a = ~td_a_n;
  assign bypass_b = ~td_b_n;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the echo canceller function control
`timescale 1ns/1ps
`default_nettype none
`include "ecfc_defines.svh"
module tb_top
  import ecfc_pkg::*;
;
  logic clk, rst, wr, rd; // Clock, reset, bus strobes
  logic [2:0] addr;
  logic [7:0] wdata, rdata;
  logic cfg_a, cfg_b, phase_reversal_select, nonlinear_proc_pin, law, fmt; // Strap pins
  logic bclk, fp_n, hit_a, hit_b, dtalk, nbhit;
  logic freeze, td_a_n, td_b_n, dfp_n, probe, byp_a, byp_b;
  logic [15:0] thr;
  logic [1:0] a_slot, b_slot;
  logic [8:0] idx; // Bit index the model expects in the design
  ecfc_func_t func;
  int err_count, compares;

  ecfc_top ecfc_top_inst (
    .SYS_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
    .CONFIG_SELECT_A(cfg_a), .CONFIG_SELECT_B(cfg_b),
    .PHASE_REVERSAL_SELECT(phase_reversal_select), .NONLINEAR_PROC_PIN(nonlinear_proc_pin),
    .LAW_SELECT(law), .FORMAT_SELECT(fmt), .BIT_CLOCK_IN(bclk),
    .FRAME_PULSE_IN_N(fp_n), .TONE_HIT_A(hit_a), .TONE_HIT_B(hit_b),
    .DOUBLE_TALK(dtalk), .NARROWBAND_HIT(nbhit), .FUNC(func),
    .DT_THRESHOLD(thr), .ADAPT_FREEZE(freeze),
    .TONE_DETECT_OUT_A_N(td_a_n), .TONE_DETECT_OUT_B_N(td_b_n),
    .DELAYED_FRAME_PULSE_OUT_N(dfp_n), .CANCELLER_A_SLOT(a_slot),
    .CANCELLER_B_SLOT(b_slot)
  );

  ecfc_tdm_master ecfc_tdm_master_inst (
    .clk(clk), .rst(rst), .td_a_n(td_a_n), .td_b_n(td_b_n),
    .bclk(bclk), .fp_n(fp_n), .probe(probe), .idx(idx),
    .bypass_a(byp_a), .bypass_b(byp_b)
  );

  // 20 MHz system clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare and count; four-state equality so an unknown bit matches only an unknown bit
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Expected settings, worked out from mode, registers and straps
  function automatic ecfc_func_t ef(input logic ctl, input logic c1,
                                    input logic [4:0] c2);
    ecfc_func_t f;
    f.controller_mode = ctl;
    f.atten_on = ctl & c1;
    f.tone_det_on = ~(ctl & c2[0]);
    f.need_phase_rev = ctl ? ~c2[1] : phase_reversal_select;
    f.nlp_on = ctl ? ~c2[4] : nonlinear_proc_pin;
    f.nb_det_on = ~(ctl & c2[2]);
    f.hpf_on = ~(ctl & c2[3]);
    f.law_alaw = law;
    f.format_itu = fmt;
    return f;
  endfunction

  // One-cycle write strobe
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    {wr, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read strobe; data stands only in the following cycle
  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    {rd, addr} <= {1'b1, a};
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({8'h00, rdata}, {8'h00, e});
  endtask

  // Long enough for the two-stage pin sync plus output flop
  task automatic settle;
    repeat (4) @(posedge clk);
    #1;
  endtask

  // Register reset values, masking and unmapped places
  task automatic t_regs;
    for (int a = 0; a < 5; a++) rd_chk(3'(a), 8'h00);
    wr_reg(`ECFC_ADDR_CTRL1, 8'hff);
    wr_reg(`ECFC_ADDR_CTRL2, 8'hff);
    wr_reg(`ECFC_ADDR_DT_THR1, 8'h5a);
    wr_reg(`ECFC_ADDR_DT_THR2, 8'hc3);
    wr_reg(3'h6, 8'hff);
    rd_chk(`ECFC_ADDR_CTRL1, 8'h01);
    rd_chk(`ECFC_ADDR_CTRL2, 8'h1f);
    rd_chk(3'h6, 8'h00);
    settle();
    chk(thr, 16'hc35a);
    rd_chk(`ECFC_ADDR_STATUS, 8'h03);
    $display("t_regs done");
  endtask

  // Controller mode: each control-2 bit alone, attenuator toggled
  task automatic t_ctrl;
    logic [4:0] c2;
    for (int i = 0; i < 6; i++) begin
      c2 = (i < 5) ? 5'(1 << i) : 5'h00;
      wr_reg(`ECFC_ADDR_CTRL2, {3'h0, c2});
      wr_reg(`ECFC_ADDR_CTRL1, {7'h00, i[0]});
      {law, fmt} <= i[2:1];
      settle();
      chk(16'(func), 16'(ef(1'b1, i[0], c2)));
    end
    $display("t_ctrl done");
  endtask

  // Standalone straps; register bits all set yet must be ignored
  task automatic t_strap;
    wr_reg(`ECFC_ADDR_CTRL2, 8'h1f);
    for (int i = 4; i < 16; i++) begin
      @(posedge clk);
      {cfg_b, cfg_a, phase_reversal_select, nonlinear_proc_pin} <= i[3:0];
      {law, fmt} <= ~i[1:0];
      settle();
      chk(16'(func), 16'(ef(1'b0, 1'b1, 5'h1f)));
      chk({15'h0000, func.law_alaw}, {15'h0000, law});
      chk(thr, 16'h0000);
    end
    $display("t_strap done");
  endtask

  // Core detections: standalone, then controller with tone and nb off
  task automatic t_core;
    logic [3:0] v;
    logic [4:0] e;
    for (int m = 0; m < 2; m++) begin
      if (m == 1) begin
        wr_reg(`ECFC_ADDR_CTRL2, 8'h05);
        @(posedge clk);
        {cfg_a, cfg_b} <= 2'b00;
        settle();
      end
      for (int j = 0; j < 16; j++) begin
        v = 4'(j);
        @(posedge clk);
        {dtalk, nbhit, hit_b, hit_a} <= v;
        @(posedge clk);
        #1;
        e = m ? {v[3], 4'b1100} : {v[3] | v[2], ~v[0], ~v[1], v[0], v[1]};
        chk({11'h000, freeze, td_a_n, td_b_n, byp_a, byp_b},
            {11'h000, e});
      end
    end
    @(posedge clk);
    {dtalk, nbhit, hit_b, hit_a} <= 4'h0;
    $display("t_core done");
  endtask

  // Bounded wait for the model's first bit of a frame
  task automatic wait_start;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if (probe && idx == 9'h000) return;
    end
    err_count++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, idx, 9'h000);
    close_out();
  endtask

  // Slot placement per port mode and delayed frame pulse, whole frame
  task automatic t_tdm;
    logic [4:0] s;
    logic [1:0] ea, eb;
    for (int m = 0; m < 4; m++) begin
      wr_reg(`ECFC_ADDR_PORT_MODE, 8'(m));
      settle();
      wait_start();
      for (int n = 0; n < 256; n++) begin
        s = idx[8:4];
        ea = {s == {3'h0, m[1], 1'b0}, s == {3'h0, m[0], 1'b0}};
        eb = {s == {3'h0, m[1], 1'b1}, s == {3'h0, m[0], 1'b1}};
        chk({11'h000, dfp_n, a_slot, b_slot},
            {11'h000, idx != 9'h040, ea, eb});
        repeat (8) @(posedge clk);
        #1;
      end
    end
    $display("t_tdm done");
  endtask

  // Counts, verdict and end of run
  task automatic close_out;
    $display("compares=%0d err_count=%0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    compares = 0;
    {rst, wr, rd, addr, wdata} = {1'b1, 13'h0000};
    {cfg_a, cfg_b, phase_reversal_select, nonlinear_proc_pin, law, fmt} = 6'h00;
    {hit_a, hit_b, dtalk, nbhit} = 4'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_ctrl();
    t_strap();
    t_core();
    t_tdm();
    close_out();
  end
endmodule
`default_nettype wire
